// File: ure_pkg.sv
// Constants, types and register map of the receive error and wake block
package ure_pkg;
   // ----------------------------------------
   // Register indices (byte per index)
   // ----------------------------------------
   localparam logic [2:0] ADR_STATUS = 3'h0;
   localparam logic [2:0] ADR_CTRL1  = 3'h1;
   localparam logic [2:0] ADR_CTRL2  = 3'h2;
   localparam logic [2:0] ADR_RXBUF  = 3'h3;
   localparam logic [2:0] ADR_BAUD   = 3'h4;
   localparam logic [2:0] ADR_INTC   = 3'h5;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int C1_ON   = 7;
   localparam int C1_NINE = 6;
   localparam int C1_PEN  = 5;
   localparam int C1_ODD  = 4;
   localparam int C1_TWO  = 3;
   localparam int C2_TEIE = 7;
   localparam int C2_TIIE = 6;
   localparam int C2_RIE  = 5;
   localparam int C2_ADEN = 4;
   localparam int C2_WAKE = 3;
   localparam int C2_RXON = 2;
   localparam int IC_GATE = 1;
   localparam int IC_GIE  = 0;
   // ----------------------------------------
   // Reset values and timing
   // ----------------------------------------
   localparam logic [7:0]  CTRL_RST   = 8'h00;
   localparam logic [7:0]  BAUD_RST   = 8'h00;
   localparam logic [7:0]  C1_WMASK   = 8'hf8;
   localparam logic [7:0]  C2_WMASK   = 8'hfc;
   localparam logic [7:0]  IC_WMASK   = 8'h03;
   localparam logic [10:0] RESUME_CYC = 11'h400;
   localparam logic [3:0]  SUB_LAST   = 4'hf;
   localparam logic [3:0]  SMP_FIRST  = 4'h7;
   localparam logic [3:0]  SMP_LAST   = 4'h9;
   // Receiver states, Gray along the frame
   typedef enum logic [2:0] {
      RX_IDLE  = 3'h0,
      RX_START = 3'h1,
      RX_DATA  = 3'h3,
      RX_PAR   = 3'h2,
      RX_STOP1 = 3'h6,
      RX_STOP2 = 3'h7
   } ure_rx_e;
   // One buffered word with its own error marks
   typedef struct packed {
      logic [8:0] data;
      logic       frame_error_flag;
      logic       parity_error_flag;
      logic       nf;
   } ure_word_s;
endpackage : ure_pkg

// File: ure_rx.sv
// Receive error flags, two-word buffer, interrupt merge and wake logic
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module ure_rx (
   input  wire logic       core_clk,   // System clock
   input  wire logic       reset,      // Async reset, high
   input  wire logic [2:0] reg_addr,   // Register index
   input  wire logic [7:0] reg_wdata,  // Write data
   input  wire logic       reg_wr,     // Write strobe
   input  wire logic       reg_rd,     // Read strobe
   output logic      [7:0] reg_rdata,  // Read data, next cycle
   input  wire logic       rx_pin,     // Serial input pin
   input  wire logic       tx_line,    // Transmitter output
   input  wire logic       tx_empty,   // Transmit register empty
   input  wire logic       tx_idle,    // Transmitter idle
   input  wire logic       pwr_down,   // Core in power-down
   output logic            tx_pin,     // Serial output pin
   output logic            wake_req,   // Wake pulse to core
   output logic            resume_busy,// Resume delay running
   output logic            glob_ie,    // Global enable to core
   output logic            uart_irq    // Combined interrupt
);
   // ----------------------------------------
   // Decode helper
   // ----------------------------------------
   function automatic logic hit(input logic s, input logic [2:0] a,
                                input logic [2:0] o);
      hit = s & (a == o);
   endfunction : hit
   logic [7:0] ctrl1_r, ctrl2_r, baud_r, intc_r;
   logic       rx_s1_r, rx_s2_r, rx_d_r;
   logic [10:0] resume_cnt_r;
   logic       wake_pend_r, armed_r, overrun_flag_r;
   ure_pkg::ure_rx_e st_r;
   logic [3:0] sub_r, bit_r;
   logic [7:0] pre_r;
   logic [2:0] smp_r;
   logic [8:0] shf_r;
   logic       nz_r, fe_r, par_r, parity_error_flag_r;
   ure_pkg::ure_word_s mem_r [0:1];
   logic       wp_r, rp_r;
   logic [1:0] cnt_r;

   // Control fields
   logic uart_on, nine, pen, odd, two, receive_int_enable, aden, rxon, gate;
   assign uart_on = ctrl1_r[ure_pkg::C1_ON];
   assign nine    = ctrl1_r[ure_pkg::C1_NINE];
   assign pen     = ctrl1_r[ure_pkg::C1_PEN];
   assign odd     = ctrl1_r[ure_pkg::C1_ODD];
   assign two     = ctrl1_r[ure_pkg::C1_TWO];
   assign receive_int_enable     = ctrl2_r[ure_pkg::C2_RIE];
   assign aden    = ctrl2_r[ure_pkg::C2_ADEN];
   assign rxon    = ctrl2_r[ure_pkg::C2_RXON];
   assign gate    = intc_r[ure_pkg::IC_GATE];
   assign glob_ie = intc_r[ure_pkg::IC_GIE];

   // Bus strobes
   logic rd_stat, rd_buf, pop;
   assign rd_stat = hit(reg_rd, reg_addr, ure_pkg::ADR_STATUS);
   assign rd_buf  = hit(reg_rd, reg_addr, ure_pkg::ADR_RXBUF);
   assign pop     = rd_buf & armed_r & (cnt_r != 2'h0);
   // ----------------------------------------
   // RX pin synchroniser and edge
   // ----------------------------------------
   // Third stage feeds the edge detector so the first stays clean
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rx_s1_r <= 1'b1;
         rx_s2_r <= 1'b1;
         rx_d_r  <= 1'b1;
      end else begin
         rx_s1_r <= rx_pin;
         rx_s2_r <= rx_s1_r;
         rx_d_r  <= rx_s2_r;
      end
   end
   logic rx_fall;
   assign rx_fall = rx_d_r & ~rx_s2_r;
   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   // Status and buffer have no write path, writes there are dropped
   // Kept through power-down
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ctrl1_r <= ure_pkg::CTRL_RST;
         ctrl2_r <= ure_pkg::CTRL_RST;
         intc_r  <= ure_pkg::CTRL_RST;
         baud_r  <= ure_pkg::BAUD_RST;
      end else begin
         if (hit(reg_wr, reg_addr, ure_pkg::ADR_CTRL1))
            ctrl1_r <= reg_wdata & ure_pkg::C1_WMASK;
         if (hit(reg_wr, reg_addr, ure_pkg::ADR_CTRL2))
            ctrl2_r <= reg_wdata & ure_pkg::C2_WMASK;
         if (hit(reg_wr, reg_addr, ure_pkg::ADR_INTC))
            intc_r <= reg_wdata & ure_pkg::IC_WMASK;
         if (hit(reg_wr, reg_addr, ure_pkg::ADR_BAUD))
            baud_r <= reg_wdata;
      end
   end
   // ----------------------------------------
   // Wake and resume delay
   // ----------------------------------------
   logic wake_arm, wake_fire;
   assign wake_arm  = pwr_down & ctrl2_r[ure_pkg::C2_WAKE] & uart_on
                      & rxon & receive_int_enable;
   assign wake_fire = wake_arm & rx_fall & ~resume_busy;
   assign resume_busy = (resume_cnt_r != 11'h000);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         resume_cnt_r <= 11'h000;
         wake_req     <= 1'b0;
      end else begin
         wake_req <= wake_fire;
         if (wake_fire)
            resume_cnt_r <= ure_pkg::RESUME_CYC;
         else if (resume_busy)
            resume_cnt_r <= resume_cnt_r - 11'h001;
      end
   end

   // Flagless wake source
   // Cleared by a status read, since the source has no flag of its own
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         wake_pend_r <= 1'b0;
      else if ((resume_cnt_r == 11'h001) & glob_ie & gate)
         wake_pend_r <= 1'b1;
      else if (rd_stat)
         wake_pend_r <= 1'b0;
   end
   // ----------------------------------------
   // Receive frame sequencer
   // ----------------------------------------
   logic rx_run, os_tick, last, vote, noisy, done;
   // Abort on power-down, also during resume
   assign rx_run  = uart_on & rxon & ~pwr_down & ~resume_busy;
   assign os_tick = (pre_r == baud_r);
   assign last    = os_tick & (sub_r == ure_pkg::SUB_LAST);
   assign vote  = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2])
                  | (smp_r[0] & smp_r[2]);
   assign noisy = ~(&smp_r) & (|smp_r);
   assign done  = rx_run & last
                  & (((st_r == ure_pkg::RX_STOP1) & ~two)
                     | (st_r == ure_pkg::RX_STOP2));

   // Prescaler gives sixteen ticks per bit
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         pre_r <= 8'h00;
         sub_r <= 4'h0;
         smp_r <= 3'h7;
      end else if (~rx_run | (st_r == ure_pkg::RX_IDLE)) begin
         pre_r <= 8'h00;
         sub_r <= 4'h0;
      end else if (os_tick) begin
         pre_r <= 8'h00;
         sub_r <= sub_r + 4'h1;
         if (sub_r >= ure_pkg::SMP_FIRST && sub_r <= ure_pkg::SMP_LAST)
            smp_r <= {smp_r[1:0], rx_s2_r};
      end else begin
         pre_r <= pre_r + 8'h01;
      end
   end

   // State, bit index and data shift
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         st_r  <= ure_pkg::RX_IDLE;
         bit_r <= 4'h0;
         shf_r <= 9'h000;
      end else if (~rx_run) begin
         st_r <= ure_pkg::RX_IDLE;
      end else if (st_r == ure_pkg::RX_IDLE) begin
         if (rx_fall) begin
            st_r  <= ure_pkg::RX_START;
            shf_r <= 9'h000;
         end
      end else if (last) begin
         unique case (st_r)
            ure_pkg::RX_START: begin
               bit_r <= 4'h0;
               st_r  <= vote ? ure_pkg::RX_IDLE : ure_pkg::RX_DATA;
            end
            ure_pkg::RX_DATA: begin
               shf_r[bit_r] <= vote;
               bit_r <= bit_r + 4'h1;
               if (bit_r == (nine ? 4'h8 : 4'h7))
                  st_r <= pen ? ure_pkg::RX_PAR : ure_pkg::RX_STOP1;
            end
            ure_pkg::RX_PAR:   st_r <= ure_pkg::RX_STOP1;
            ure_pkg::RX_STOP1: st_r <= two ? ure_pkg::RX_STOP2 : ure_pkg::RX_IDLE;
            ure_pkg::RX_STOP2: st_r <= ure_pkg::RX_IDLE;
            default:           st_r <= ure_pkg::RX_IDLE;
         endcase
      end
   end

   // Per-frame error collection
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         nz_r   <= 1'b0;
         fe_r   <= 1'b0;
         par_r  <= 1'b0;
         parity_error_flag_r <= 1'b0;
      end else if (st_r == ure_pkg::RX_IDLE) begin
         nz_r   <= 1'b0;
         fe_r   <= 1'b0;
         par_r  <= 1'b0;
         parity_error_flag_r <= 1'b0;
      end else if (last) begin
         nz_r <= nz_r | noisy;
         if (st_r == ure_pkg::RX_DATA)
            par_r <= par_r ^ vote;
         if (st_r == ure_pkg::RX_PAR)
            parity_error_flag_r <= pen & ((par_r ^ vote) != odd);
         if (st_r == ure_pkg::RX_STOP1 && !vote)
            fe_r <= 1'b1;
      end
   end
   // ----------------------------------------
   // Two-word receive buffer
   // ----------------------------------------
   ure_pkg::ure_word_s in_w, head;
   logic push, ovr, rx_available_flag, top;
   // Word carries its frame and parity marks
   assign in_w = {shf_r, fe_r | ~vote, parity_error_flag_r, nz_r | noisy};
   // Full buffer drops the new word unless a pop in the same cycle makes room
   assign push = done & ((cnt_r != 2'h2) | pop);
   assign ovr  = done & (cnt_r == 2'h2) & ~pop;
   assign rx_available_flag = (cnt_r != 2'h0);
   assign head = rx_available_flag ? mem_r[rp_r] : '0;
   assign top  = nine ? head.data[8] : head.data[7];

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mem_r[0] <= '0;
         mem_r[1] <= '0;
         wp_r     <= 1'b0;
         rp_r     <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_w;
            wp_r        <= ~wp_r;
         end
         // Pop drops noise mark with its word
         if (pop)
            rp_r <= ~rp_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

   // Overrun flag, set wins over clear
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         overrun_flag_r <= 1'b0;
      else if (ovr)
         overrun_flag_r <= 1'b1;
      else if (pop)
         overrun_flag_r <= 1'b0;
   end

   // Status read arms the clearing buffer read
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         armed_r <= 1'b0;
      else if (rd_stat)
         armed_r <= 1'b1;
      else if (rd_buf)
         armed_r <= 1'b0;
   end
   // ----------------------------------------
   // Read data
   // ----------------------------------------
   logic [7:0] stat;
   // Status is a view of hardware state only
   assign stat = {head.parity_error_flag, head.nf, overrun_flag_r, head.frame_error_flag,
                  st_r == ure_pkg::RX_IDLE, rx_available_flag, tx_idle, tx_empty};
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         reg_rdata <= 8'h00;
      else if (!reg_rd)
         reg_rdata <= 8'h00;
      else
         unique case (reg_addr)
            ure_pkg::ADR_STATUS: reg_rdata <= stat;
            ure_pkg::ADR_CTRL1:  reg_rdata <= {ctrl1_r[7:3], head.data[8], 2'h0};
            ure_pkg::ADR_CTRL2:  reg_rdata <= ctrl2_r;
            ure_pkg::ADR_RXBUF:  reg_rdata <= head.data[7:0];
            ure_pkg::ADR_BAUD:   reg_rdata <= baud_r;
            ure_pkg::ADR_INTC:   reg_rdata <= intc_r;
            default:             reg_rdata <= 8'h00;
         endcase
   end
   // ----------------------------------------
   // Interrupt merge and TX pin
   // ----------------------------------------
   logic src_avail, src_addr, src_any;
   assign src_avail = rx_available_flag & (~aden | top);
   assign src_addr  = rx_available_flag & aden & top;
   assign src_any = (tx_empty & ctrl2_r[ure_pkg::C2_TEIE])
                  | (tx_idle & ctrl2_r[ure_pkg::C2_TIIE])
                  | (receive_int_enable & (src_avail | overrun_flag_r))
                  | src_addr | wake_pend_r;

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         uart_irq <= 1'b0;
      else
         uart_irq <= gate & src_any;
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset)
         tx_pin <= 1'b1;
      else
         tx_pin <= pwr_down | tx_line;
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   nf_with_data_a: assert property (@(posedge core_clk) disable iff (reset)
      (push & (nz_r | noisy)) |=> (rx_available_flag & mem_r[$past(wp_r)].nf))
      else $error("noise flag missing with data");
   nf_clear_seq_a: assert property (@(posedge core_clk) disable iff (reset)
      $fell(stat[6]) |-> $past(pop))
      else $error("noise flag cleared without sequence");
   frame_err_a: assert property (@(posedge core_clk) disable iff (reset)
      (push & ~vote) |=> mem_r[$past(wp_r)].frame_error_flag)
      else $error("low stop bit missed");
   resume_len_a: assert property (@(posedge core_clk) disable iff (reset)
      wake_fire |=> (resume_cnt_r == 11'h400) ##1 resume_busy)
      else $error("resume delay wrong");
   resume_drop_a: assert property (@(posedge core_clk) disable iff (reset)
      resume_busy |-> !push)
      else $error("word taken during resume");
   status_ro_a: assert property (@(posedge core_clk) disable iff (reset)
      (hit(reg_wr, reg_addr, ure_pkg::ADR_STATUS) & ~pop & ~ovr)
      |=> (overrun_flag_r == $past(overrun_flag_r)))
      else $error("status changed by write");
   gate_block_a: assert property (@(posedge core_clk) disable iff (reset)
      !gate |=> !uart_irq)
      else $error("interrupt passed closed gate");
   avail_irq_a: assert property (@(posedge core_clk) disable iff (reset)
      (rx_available_flag & ~aden & receive_int_enable & gate) |=> uart_irq)
      else $error("data interrupt missing");
   tx_high_a: assert property (@(posedge core_clk) disable iff (reset)
      pwr_down |=> tx_pin)
      else $error("tx not high in power-down");
   wake_irq_a: assert property (@(posedge core_clk) disable iff (reset)
      $rose(wake_pend_r) |-> $past(resume_cnt_r == 11'h001 & glob_ie & gate))
      else $error("wake interrupt without enables");
endmodule : ure_rx

// File: ure_tx_model.sv
// Remote serial transmitter model that drives the receive line
`timescale 1ns/100ps
module ure_tx_model #(
   parameter int BIT_CLKS = 16        // Clocks per bit at divisor zero
) (
   input  wire logic core_clk,        // System clock
   output logic      rx_line          // Serial line to receiver
);
   // ----------------------------------------
   // Line driver
   // ----------------------------------------
   // Line idles high between frames, as a real transmitter leaves it
   initial rx_line = 1'b1;

   // One bit; optional one-clock glitch mid-bit outvoted by the majority
   task automatic put_bit(input logic v, input logic glitch);
      for (int i = 0; i < BIT_CLKS; i++) begin
         @(posedge core_clk);
         rx_line <= (glitch && i == BIT_CLKS / 2) ? ~v : v;
      end
   endtask : put_bit

   // One frame, LSB first; faults only when the bench asks for them
   task automatic send(input logic [8:0] w, input logic nine, input logic par,
                       input logic odd, input logic two, input logic bad_stop,
                       input logic bad_par, input logic noisy);
      logic p;
      p = ^(nine ? w : {1'b0, w[7:0]}) ^ odd ^ bad_par;
      put_bit(1'b0, 1'b0);
      for (int b = 0; b < 9; b++) begin
         if (b < 8 || nine) begin
            put_bit(w[b], noisy && b == 2);
         end
      end
      if (par) begin
         put_bit(p, 1'b0);
      end
      // Fault on the last stop, so two-stop frames fail on the second one
      put_bit(two | ~bad_stop, 1'b0);
      if (two) begin
         put_bit(~bad_stop, 1'b0);
      end
      // Idle gap leaves time for the word to land in the buffer
      put_bit(1'b1, 1'b0);
   endtask : send
endmodule : ure_tx_model

// File: ure_rx_tb.sv
// Self-checking bench for the receive error, interrupt and wake block
`timescale 1ns/100ps
module ure_rx_tb;
   logic        core_clk, reset, reg_wr, reg_rd, rx_pin, tx_line, tx_empty;
   logic        tx_idle, pwr_down, tx_pin, wake_req, resume_busy, glob_ie, uart_irq;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, w;
   logic [7:0]  exp_q[$];            // Expected read data, oldest first
   logic        rd_seen = 1'b0;      // Read answer due this cycle
   logic [11:0] busy_cnt = 12'h000;  // Cycles with resume delay running
   logic [31:0] seed, v;
   int          miscompares, tests_run;

   ure_rx ure_rx_i (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .rx_pin(rx_pin), .tx_line(tx_line), .tx_empty(tx_empty), .tx_idle(tx_idle),
      .pwr_down(pwr_down), .tx_pin(tx_pin), .wake_req(wake_req),
      .resume_busy(resume_busy), .glob_ie(glob_ie), .uart_irq(uart_irq));
   ure_tx_model ure_tx_model_i (.core_clk(core_clk), .rx_line(rx_pin));

   // ----------------------------------------
   // Clock, helpers and checking
   // ----------------------------------------
   initial core_clk = 1'b0;
   always #20 core_clk = ~core_clk;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read only notes the expectation; the watcher below compares
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
   endtask : rd

   // Status access then buffer read, the clearing sequence
   task automatic pop(input logic [7:0] st, input logic [7:0] d);
      rd(ure_pkg::ADR_STATUS, st);
      rd(ure_pkg::ADR_RXBUF, d);
   endtask : pop

   // Interrupt is registered, so give the cause two edges to show
   task automatic see_irq(input logic e);
      repeat (2) @(posedge core_clk);
      #1;
      chk("uart_irq", {15'h0000, e}, {15'h0000, uart_irq});
      @(posedge core_clk);
   endtask : see_irq

   // Read answer stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_seen) begin
         chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, reg_rdata});
      end
      rd_seen <= reg_rd;
   end

   // Length of the resume delay, counted at the port
   always @(posedge core_clk) begin
      if (resume_busy === 1'b1) begin
         busy_cnt <= busy_cnt + 12'h001;
      end
   end

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // Hang guard, far beyond the expected few thousand cycles
   initial begin
      #2000000;
      miscompares++;
      end_of_test();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {reset, tx_line} = 2'b11;
      {reg_wr, reg_rd, tx_empty, tx_idle, pwr_down} = 5'h00;
      {reg_addr, reg_wdata} = 11'h000;
      {miscompares, tests_run} = 0;
      seed = 32'd10;
      repeat (2) @(posedge core_clk);
      reset <= 1'b0;
      // Reset values, refused writes, unmapped place
      rd(ure_pkg::ADR_STATUS, 8'h08);
      wr(ure_pkg::ADR_STATUS, 8'hff);
      rd(ure_pkg::ADR_STATUS, 8'h08);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
      wr(ure_pkg::ADR_BAUD, 8'ha5);
      rd(ure_pkg::ADR_BAUD, 8'ha5);
      wr(ure_pkg::ADR_BAUD, 8'h00);
      wr(ure_pkg::ADR_CTRL1, 8'hff);
      rd(ure_pkg::ADR_CTRL1, 8'hf8);
      // TX pin follows the line, forced high in power-down
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         v = xs();
         tx_line <= v[0];
         pwr_down <= v[1] & v[2];
         @(posedge core_clk);
         #1;
         chk("tx_pin", {15'h0000, v[0] | (v[1] & v[2])}, {15'h0000, tx_pin});
      end
      @(posedge core_clk);
      pwr_down <= 1'b0;
      // Transmit sources, their enables and the gate
      wr(ure_pkg::ADR_INTC, 8'h03);
      tx_empty <= 1'b1;
      see_irq(1'b0);
      wr(ure_pkg::ADR_CTRL2, 8'h80);
      see_irq(1'b1);
      tx_empty <= 1'b0;
      tx_idle <= 1'b1;
      see_irq(1'b0);
      wr(ure_pkg::ADR_CTRL2, 8'h40);
      see_irq(1'b1);
      wr(ure_pkg::ADR_INTC, 8'h01);
      see_irq(1'b0);
      chk("glob_ie", 16'h0001, {15'h0000, glob_ie});
      wr(ure_pkg::ADR_INTC, 8'h03);
      tx_idle <= 1'b0;
      // Plain random word; unarmed buffer reads do not pop
      wr(ure_pkg::ADR_CTRL1, 8'h88);
      wr(ure_pkg::ADR_CTRL2, 8'h24);
      // Empty-buffer read disarms the status access made at start
      rd(ure_pkg::ADR_RXBUF, 8'h00);
      w = xs();
      ure_tx_model_i.send({1'b0, w}, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      see_irq(1'b1);
      rd(ure_pkg::ADR_RXBUF, w);
      rd(ure_pkg::ADR_RXBUF, w);
      pop(8'h0c, w);
      see_irq(1'b0);
      // Framing error, noisy word, then a third word overruns
      ure_tx_model_i.send(9'h011, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
      ure_tx_model_i.send(9'h022, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      ure_tx_model_i.send(9'h033, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      rd(ure_pkg::ADR_CTRL1, 8'h88);
      pop(8'h3c, 8'h11);
      pop(8'h4c, 8'h22);
      rd(ure_pkg::ADR_STATUS, 8'h08);
      // Parity, both types, right and wrong
      for (int k = 0; k < 4; k++) begin
         wr(ure_pkg::ADR_CTRL1, {3'b101, k[0], 4'h0});
         ure_tx_model_i.send(9'h05a, 1'b0, 1'b1, k[0], 1'b0, 1'b0, k[1], 1'b0);
         pop({k[1], 7'h0c}, 8'h5a);
      end
      // Address detect, eight- and nine-bit words, top bit low and high
      wr(ure_pkg::ADR_CTRL2, 8'h34);
      for (int k = 0; k < 4; k++) begin
         wr(ure_pkg::ADR_CTRL1, {1'b1, k[1], 6'h00});
         v = k[1] ? {23'h0, k[0], 8'h55} : {24'h0, k[0], 7'h2a};
         ure_tx_model_i.send(v[8:0], k[1], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         see_irq(k[0]);
         rd(ure_pkg::ADR_CTRL1, {1'b1, k[1], 3'h0, k[1] & k[0], 2'h0});
         pop(8'h0c, v[7:0]);
      end
      // Wake from power-down by the start of a frame that is then dropped
      wr(ure_pkg::ADR_CTRL2, 8'h2c);
      @(posedge core_clk);
      pwr_down <= 1'b1;
      fork
         ure_tx_model_i.send(9'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
         begin
            for (int n = 0; n < 50 && wake_req !== 1'b1; n++) begin
               @(posedge core_clk);
               #1;
            end
            chk("wake_req", 16'h0001, {15'h0000, wake_req});
            @(posedge core_clk);
            pwr_down <= 1'b0;
         end
      join
      see_irq(1'b0);
      for (int n = 0; n < 1200 && resume_busy === 1'b1; n++) begin
         @(posedge core_clk);
      end
      chk("resume cycles", 16'(ure_pkg::RESUME_CYC), {4'h0, busy_cnt});
      see_irq(1'b1);
      rd(ure_pkg::ADR_STATUS, 8'h08);
      see_irq(1'b0);
      rd(ure_pkg::ADR_CTRL1, 8'hc0);
      rd(ure_pkg::ADR_CTRL2, 8'h2c);
      rd(ure_pkg::ADR_INTC, 8'h03);
      repeat (3) @(posedge core_clk);
      end_of_test();
   end
endmodule : ure_rx_tb
